// >>> hw/i2c_regs_pkg.sv
package i2c_regs_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0] IDX_RX_BYTE = 6'h06;
    localparam logic [5:0] IDX_STATUS_MAIN = 6'h07;
    localparam logic [5:0] IDX_CONTROL_MAIN = 6'h10;
    localparam logic [5:0] IDX_BUS_RATE_CFG = 6'h11;
    localparam logic [5:0] IDX_OWN_ADDRESS_A = 6'h12;
    localparam logic [5:0] IDX_OWN_ADDRESS_B = 6'h13;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ==========================================================
    // control_main fields
    localparam int CR_INTERFACE_ON = 5;
    localparam int CR_GENERAL_CALL_ON = 4;
    localparam int CR_START = 3;
    localparam int CR_ACK = 2;
    localparam int CR_STOP = 1;
    localparam int CR_IRQ_ON = 0;

    // ==========================================================
    // bus_rate_cfg fields and divider arithmetic
    localparam int RATE_SPEED_SELECT = 7;
    localparam logic [8:0] STD_MUL = 9'h003;
    localparam logic [8:0] STD_ADD = 9'h00b;
    localparam logic [8:0] FAST_MUL = 9'h002;
    localparam logic [8:0] FAST_ADD = 9'h009;

    // ==========================================================
    // address recognition constants
    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
    localparam logic [7:0] NEVER_ADDR = 8'h01;
    localparam logic [4:0] TEN_BIT_HEADER = 5'h1e;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic start_det;
        logic stop_det;
        logic start_done;
        logic stop_done;
        logic addr_hit;
        logic addr_done;
        logic ten_hdr_sent;
        logic byte_done;
        logic byte_was_tx;
        logic rx_valid;
        logic no_ack;
        logic arb_lost;
        logic bus_err;
    } bus_event_t;

    typedef struct packed {
        logic no_ack_flag;
        logic stop_seen_flag;
        logic lost_arbitration;
        logic bus_fault_flag;
    } error_flags_t;

    typedef struct packed {
        logic interface_on;
        logic general_call_on;
        logic start_req;
        logic ack_on;
        logic stop_req;
        logic irq_on;
        logic controller_role;
        logic bus_speed_select;
        logic [6:0] clock_divider;
    } control_t;

    typedef struct packed {
        logic own7;
        logic gcall;
        logic hdr10;
        logic low10;
    } addr_match_t;

endpackage

// >>> hw/i2c_rate_divider.sv
`timescale 1ns/1ps
module i2c_rate_divider (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_speed_select,
    input wire logic [6:0] i_clock_divider,
    output logic o_tick
);
    import i2c_regs_pkg::*;

    logic [8:0] period;
    logic [8:0] count;

    // ==========================================================
    // period: 3*div+11 standard, 2*div+9 fast
    always_comb begin
        if (i_speed_select) begin
            period = ({2'b00, i_clock_divider} * STD_MUL) + STD_ADD; // [R9]
        end else begin
            period = ({2'b00, i_clock_divider} * FAST_MUL) + FAST_ADD; // [R9]
        end
    end

    // a new divider value takes hold at once; if shortened below the count, the next cycle wraps
    always_ff @(posedge i_clock) begin
        if (i_rst || !i_run) begin
            count <= 9'h000;
            o_tick <= 1'b0;
        end else if (count >= period - 9'h001) begin
            count <= 9'h000;
            o_tick <= 1'b1;
        end else begin
            count <= count + 9'h001;
            o_tick <= 1'b0;
        end
    end

endmodule

// >>> hw/i2c_control_status_registers.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: interface off clears all control and status bits but stop and busy; bus outputs released.
// R2: software writes control twice to enable; first write sets only interface-on.
// R3: interface on switches the pins to their two-wire alternate function.
// R4: general call 00h acknowledged when enabled, 01h ignored; disable clears enable.
// R5: start request gives (repeated) start; cleared when start sent or on disable.
// R6: acknowledge-enable returns ack after received bytes; disable clears it.
// R7: master stop request makes stop; hardware clears it; disable keeps it.
// R8: slave transmitter stop request releases lines after last byte; software clears it.
// R9: speed select survives disable; rate is cpu/(3d+11) standard or cpu/(2d+9) fast.
// R10: software keeps divider at least 3 standard, at least 2 fast.
// R11: 7-bit match on bits 7-1, direction ignored, 01h never; addresses survive disable.
// R12: 10-bit address uses own_address_b bits 2-1 above own_address_a; bit 0 zero.
// R13: first received byte captured automatically; later ones only after a receive read.
// R14: summary flag set on any event; error-register read or disable clears it.
// R15: 10-bit header flag set after header sent; status read then write clears.
// R16: direction flag shows transmitted byte while byte-done; clears with it, stop, loss.
// R17: busy set on start, cleared on stop or bus fault; frozen while disabled.
// R18: byte-done holds clock low; cleared by status read then data access, or disable.
// R19: byte-done after ack pulse; for address byte only after address-complete event.
// R20: address hit sets on match or general call, holds clock low, status read clears.
// R21: master role set by start request; cleared by stop, lost arbitration, disable.
// R22: start-sent set after start made; status read then address write clears.
// R23: error flags live in error register; clock not held low while any set.
// R24: unused bits of control and own_address_b read zero, writes ignored.
module i2c_control_status_registers (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input i2c_regs_pkg::bus_event_t i_evt,
    input i2c_regs_pkg::error_flags_t i_err,
    input wire logic i_error_read,
    input wire logic i_tx_write,
    input wire logic [7:0] i_rx_data,
    input wire logic [7:0] i_addr_byte,
    input wire logic i_addr_strobe,
    output i2c_regs_pkg::control_t o_ctl,
    output i2c_regs_pkg::addr_match_t o_match,
    output logic o_rx_ready,
    output logic o_scl_hold,
    output logic o_release_lines,
    output logic o_alt_function,
    output logic o_rate_tick
);
    import i2c_regs_pkg::*;
    // ==========================================================
    // register state
    logic interface_on;
    logic general_call_on;
    logic start_req;
    logic ack_on;
    logic stop_req;
    logic irq_on;
    logic bus_speed_select;
    logic [6:0] clock_divider;
    logic [7:0] own_address_a;
    logic [1:0] own_address_high;
    logic [7:0] rx_byte;
    logic any_event_flag;
    logic ten_bit_header_sent;
    logic sent_not_received;
    logic bus_busy;
    logic byte_done_flag;
    logic own_address_hit;
    logic controller_role;
    logic start_sent_flag;
    logic status_read_armed;
    logic addr_done_pending;
    logic rx_ready;
    logic [7:0] read_mux;
    logic [7:0] status_main;
    // ==========================================================
    // avalon slave: one wait cycle, then a single cycle with waitrequest low
    logic request;
    logic access_done;
    logic [5:0] index;
    logic [7:0] wdata;
    logic cr_write;
    logic rx_read;
    logic sr1_read;
    assign request = i_avs_read || i_avs_write;
    assign access_done = request && !o_avs_waitrequest;
    assign index = i_avs_address[7:2];
    assign wdata = i_avs_writedata[7:0];
    assign cr_write = access_done && i_avs_write && (index == IDX_CONTROL_MAIN);
    assign rx_read = access_done && i_avs_read && (index == IDX_RX_BYTE);
    assign sr1_read = access_done && i_avs_read && (index == IDX_STATUS_MAIN);
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
        end else if (request && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end
    assign status_main = {any_event_flag, ten_bit_header_sent, sent_not_received, bus_busy,
                          byte_done_flag, own_address_hit, controller_role, start_sent_flag};
    always_comb begin
        case (index)
            IDX_RX_BYTE: read_mux = rx_byte;
            IDX_STATUS_MAIN: read_mux = status_main;
            IDX_CONTROL_MAIN: read_mux = {2'b00, interface_on, general_call_on,
                                          start_req, ack_on, stop_req, irq_on}; // [R24]
            IDX_BUS_RATE_CFG: read_mux = {bus_speed_select, clock_divider};
            IDX_OWN_ADDRESS_A: read_mux = own_address_a;
            IDX_OWN_ADDRESS_B: read_mux = {5'b00000, own_address_high, 1'b0}; // [R24] [R12]
            default: read_mux = REG_RESET;
        endcase
    end
    // read data is latched when the request is first seen and stands on the answer edge
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read && o_avs_waitrequest) begin
            o_avs_readdata <= {24'h000000, read_mux};
        end
    end
    // ==========================================================
    // control_main
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            interface_on <= 1'b0;
            general_call_on <= 1'b0;
            start_req <= 1'b0;
            ack_on <= 1'b0;
            stop_req <= 1'b0;
            irq_on <= 1'b0;
        end else if (cr_write) begin
            if (!interface_on) begin
                // first write after disable wakes the block only
                interface_on <= wdata[CR_INTERFACE_ON]; // [R2]
            end else if (!wdata[CR_INTERFACE_ON]) begin
                interface_on <= 1'b0;
                general_call_on <= 1'b0; // [R4]
                start_req <= 1'b0; // [R5]
                ack_on <= 1'b0; // [R6]
                irq_on <= 1'b0; // [R1]
                stop_req <= wdata[CR_STOP]; // [R7]
            end else begin
                general_call_on <= wdata[CR_GENERAL_CALL_ON];
                start_req <= wdata[CR_START];
                ack_on <= wdata[CR_ACK];
                stop_req <= wdata[CR_STOP];
                irq_on <= wdata[CR_IRQ_ON];
            end
        end else if (!interface_on) begin
            general_call_on <= 1'b0; // [R1]
            start_req <= 1'b0;
            ack_on <= 1'b0;
            irq_on <= 1'b0;
        end else begin
            if (i_evt.start_done) begin
                start_req <= 1'b0; // [R5]
            end
            // only the master clears stop; a slave transmitter leaves it to software
            if (i_evt.stop_done && controller_role) begin
                stop_req <= 1'b0; // [R7] [R8]
            end
        end
    end
    // ==========================================================
    // configuration registers, untouched by disable
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bus_speed_select <= 1'b0;
            clock_divider <= 7'h00;
            own_address_a <= REG_RESET;
            own_address_high <= 2'b00;
        end else if (access_done && i_avs_write) begin
            case (index)
                IDX_BUS_RATE_CFG: begin
                    bus_speed_select <= wdata[RATE_SPEED_SELECT]; // [R9]
                    clock_divider <= wdata[6:0];
                end
                IDX_OWN_ADDRESS_A: own_address_a <= wdata; // [R11]
                IDX_OWN_ADDRESS_B: own_address_high <= wdata[2:1]; // [R12] [R24]
                default: begin
                end
            endcase
        end
    end
    // ==========================================================
    // status read arms the two-step clears
    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            status_read_armed <= 1'b0;
        end else if (sr1_read) begin
            status_read_armed <= 1'b1;
        end else if (rx_read || i_tx_write || cr_write) begin
            status_read_armed <= 1'b0;
        end
    end
    // ==========================================================
    // status_main flags; set wins over a clear in the same cycle, except controller_role where the clear wins
    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            any_event_flag <= 1'b0; // [R14]
        end else begin
            if (i_error_read || (status_read_armed && (rx_read || i_tx_write || cr_write)) ||
                (sr1_read && own_address_hit && !byte_done_flag && !start_sent_flag &&
                 !ten_bit_header_sent)) begin
                any_event_flag <= 1'b0; // [R14]
            end
            if (i_evt.byte_done || i_evt.addr_hit || i_evt.start_done || i_evt.no_ack ||
                i_evt.stop_det || i_evt.arb_lost || i_evt.bus_err || i_evt.ten_hdr_sent ||
                i_evt.addr_done) begin
                any_event_flag <= 1'b1; // [R14]
            end
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            ten_bit_header_sent <= 1'b0; // [R15]
        end else if (i_evt.ten_hdr_sent) begin
            ten_bit_header_sent <= 1'b1; // [R15]
        end else if (status_read_armed && i_tx_write) begin
            ten_bit_header_sent <= 1'b0; // [R15]
        end
    end
    // a transmitted byte may only flag done once the address-complete step is cleared
    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            addr_done_pending <= 1'b0;
        end else if (i_evt.addr_done) begin
            addr_done_pending <= 1'b1; // [R19]
        end else if (status_read_armed && cr_write) begin
            addr_done_pending <= 1'b0; // [R19]
        end
    end
    logic byte_done_set;
    logic byte_done_clear;
    assign byte_done_set = i_evt.byte_done && !(i_evt.byte_was_tx && addr_done_pending); // [R19]
    assign byte_done_clear = status_read_armed && (rx_read || i_tx_write); // [R18]
    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            byte_done_flag <= 1'b0; // [R18]
        end else if (byte_done_set) begin
            byte_done_flag <= 1'b1; // [R18]
        end else if (byte_done_clear) begin
            byte_done_flag <= 1'b0; // [R18]
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            sent_not_received <= 1'b0; // [R16]
        end else if (byte_done_set) begin
            sent_not_received <= i_evt.byte_was_tx; // [R16]
        end else if (byte_done_clear || i_evt.stop_det || i_evt.arb_lost) begin
            sent_not_received <= 1'b0; // [R16]
        end
    end
    // busy is frozen, not cleared, while the interface is off
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bus_busy <= 1'b0;
        end else if (interface_on) begin
            if (i_evt.start_det) begin
                bus_busy <= 1'b1; // [R17]
            end else if (i_evt.stop_det || i_evt.bus_err) begin
                bus_busy <= 1'b0; // [R17]
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            own_address_hit <= 1'b0; // [R20]
        end else if (i_evt.addr_hit) begin
            own_address_hit <= 1'b1; // [R20]
        end else if (sr1_read) begin
            own_address_hit <= 1'b0; // [R20]
        end
    end
    // role is taken from slave only while the bus is free; a master keeps it for repeats
    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on || (cr_write && !wdata[CR_INTERFACE_ON])) begin
            controller_role <= 1'b0; // [R21]
        end else if (i_evt.stop_det || i_evt.arb_lost) begin
            controller_role <= 1'b0; // [R21]
        end else if (start_req && !bus_busy) begin
            controller_role <= 1'b1; // [R21] [R5]
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            start_sent_flag <= 1'b0; // [R22]
        end else if (i_evt.start_done) begin
            start_sent_flag <= 1'b1; // [R22]
        end else if (status_read_armed && i_tx_write) begin
            start_sent_flag <= 1'b0; // [R22]
        end
    end
    // ==========================================================
    // receive path: one byte of room, reopened by a receive read
    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            rx_ready <= 1'b0;
        end else if (i_evt.addr_hit || i_evt.addr_done || rx_read) begin
            rx_ready <= 1'b1; // [R13]
        end else if (i_evt.rx_valid) begin
            rx_ready <= 1'b0; // [R13]
        end
    end
    // the last byte is kept across disable so software can still read it
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rx_byte <= REG_RESET;
        end else if (interface_on && i_evt.rx_valid && rx_ready) begin
            rx_byte <= i_rx_data; // [R13]
        end
    end
    // ==========================================================
    // address recognition, sampled when the engine strobes a received address byte
    always_ff @(posedge i_clock) begin
        if (i_rst || !interface_on) begin
            o_match <= '0;
        end else if (i_addr_strobe) begin
            o_match.own7 <= (i_addr_byte[7:1] == own_address_a[7:1]) &&
                            (i_addr_byte != NEVER_ADDR); // [R11]
            o_match.gcall <= general_call_on && (i_addr_byte == GENERAL_CALL_ADDR); // [R4]
            o_match.hdr10 <= (i_addr_byte[7:3] == TEN_BIT_HEADER) &&
                             (i_addr_byte[2:1] == own_address_high); // [R12]
            o_match.low10 <= (i_addr_byte == own_address_a); // [R12]
        end
    end
    // ==========================================================
    // bus-facing outputs
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_scl_hold <= 1'b0;
            o_release_lines <= 1'b1;
            o_alt_function <= 1'b0;
            o_rx_ready <= 1'b0;
        end else begin
            // an error flag lets the clock go even with a pending software step
            o_scl_hold <= interface_on && !(|i_err) && !o_release_lines &&
                          (byte_done_flag || own_address_hit || start_sent_flag ||
                           ten_bit_header_sent); // [R18] [R20] [R23]
            o_release_lines <= !interface_on || (stop_req && !controller_role &&
                               byte_done_flag && sent_not_received); // [R1] [R8]
            o_alt_function <= interface_on; // [R3]
            o_rx_ready <= rx_ready;
        end
    end
    assign o_ctl = '{interface_on: interface_on, general_call_on: general_call_on,
                     start_req: start_req, ack_on: ack_on, stop_req: stop_req,
                     irq_on: irq_on, controller_role: controller_role,
                     bus_speed_select: bus_speed_select, clock_divider: clock_divider}; // [R6]
    // ==========================================================
    // bit-rate tick; divider below the safe minimum is software's fault
    i2c_rate_divider u_rate (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_run(interface_on),
        .i_speed_select(bus_speed_select),
        .i_clock_divider(clock_divider), // [R10]
        .o_tick(o_rate_tick)
    );
endmodule

// >>> tb/i2c_csr_assertions.sv
`timescale 1ns/1ps
module i2c_csr_assertions (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input i2c_regs_pkg::control_t o_ctl,
    input i2c_regs_pkg::addr_match_t o_match,
    input wire logic o_release_lines,
    input wire logic o_alt_function
);
    import i2c_regs_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // register bus handshake
    chk_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_wait_cause: assert property ($fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write))
        else $error("waitrequest dropped without a request");
    // ==========================================================
    // interface off
    chk_off_clear: assert property (!o_ctl.interface_on |-> !(o_ctl.general_call_on ||
        o_ctl.start_req || o_ctl.ack_on || o_ctl.irq_on))
        else $error("control bits set while interface off");
    chk_role_off: assert property (!o_ctl.interface_on |-> !o_ctl.controller_role)
        else $error("controller role while interface off");
    chk_off_release: assert property (!o_ctl.interface_on [*2] |-> o_release_lines)
        else $error("lines not released while off");
    chk_match_off: assert property (!o_ctl.interface_on [*2] |-> o_match == '0)
        else $error("address match while off");
    chk_alt_follow: assert property (o_alt_function == $past(o_ctl.interface_on))
        else $error("alternate function not following interface on");
    chk_speed_kept: assert property ($fell(o_ctl.interface_on) |->
        $stable(o_ctl.bus_speed_select) && $stable(o_ctl.clock_divider))
        else $error("rate setting lost on disable");
    cover property (i_avs_read && !o_avs_waitrequest);
    cover property ($fell(o_ctl.interface_on));
    cover property (o_ctl.controller_role);
endmodule
bind i2c_control_status_registers i2c_csr_assertions u_chk (.i_clock, .i_rst, .i_avs_read,
    .i_avs_write, .o_avs_waitrequest, .o_ctl, .o_match, .o_release_lines, .o_alt_function);

// >>> tb/i2c_engine_model.sv
`timescale 1ns/1ps
module i2c_engine_model (
    input wire logic i_clock,
    input wire logic i_go,
    input wire logic [2:0] i_op,
    input wire logic [7:0] i_data,
    output i2c_regs_pkg::bus_event_t o_evt,
    output logic [7:0] o_rx_data
);
    import i2c_regs_pkg::*;
    // data is inverted outside a capture so a stale byte never matches
    always_ff @(posedge i_clock) begin
        o_evt <= '0;
        o_rx_data <= ~i_data;
        if (i_go) begin
            case (i_op)
                3'h1: begin
                    o_evt.start_det <= 1'b1;
                    o_evt.start_done <= 1'b1;
                end
                3'h2: o_evt.stop_det <= 1'b1;
                3'h3: o_evt.addr_hit <= 1'b1;
                3'h4: begin
                    o_evt.byte_done <= 1'b1;
                    o_evt.rx_valid <= 1'b1;
                    o_rx_data <= i_data;
                end
                default: begin
                    o_evt.byte_done <= 1'b1;
                    o_evt.byte_was_tx <= 1'b1;
                end
            endcase
        end
    end
endmodule

// >>> tb/i2c_control_status_registers_tb.sv
`timescale 1ns/1ps
module i2c_control_status_registers_tb;
    import i2c_regs_pkg::*;
    logic clock, rst, rd, wr, waitr, txw, go, tick, hold, stb;
    logic [7:0] addr, q, rxd, dat, ab;
    logic [3:0] er;
    addr_match_t m;
    logic [2:0] op;
    logic [31:0] wdata, rdata, seed;
    bus_event_t evt;
    int mismatches, checked, cycles, n;
    i2c_control_status_registers dut (.i_clock(clock), .i_rst(rst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitr), .i_evt(evt), .i_err(er), .i_error_read(1'b0),
        .i_tx_write(txw), .i_rx_data(rxd), .i_addr_byte(ab), .i_addr_strobe(stb),
        .o_ctl(), .o_match(m), .o_rx_ready(), .o_scl_hold(hold), .o_release_lines(),
        .o_alt_function(), .o_rate_tick(tick));
    i2c_engine_model partner (.i_clock(clock), .i_go(go), .i_op(op), .i_data(dat),
        .o_evt(evt), .o_rx_data(rxd));
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // bus master: request held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= {24'h0, d};
        rd <= !w;
        wr <= w;
        @(posedge clock);
        while (waitr !== 1'b0) begin
            @(posedge clock);
        end
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic ev(input logic [2:0] o, input logic [7:0] d);
        op <= o;
        dat <= d;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic wt(output int c);
        c = 0;
        while (tick !== 1'b1 && c < 2000) begin
            @(posedge clock);
            c++;
        end
        @(posedge clock);
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        {rd, wr, txw, go, stb, ab, er, op, dat, addr, wdata, mismatches, checked, cycles} = '0;
        seed = 32'h0d9c;
        rst = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            acc(0, 8'h18 + 8'(i * 4), 0);
            chk(q, 8'h00);
        end
        acc(1, 8'h40, 8'h3f); acc(0, 8'h40, 0); chk(q, 8'h20);
        acc(1, 8'h40, 8'hf6); acc(0, 8'h40, 0); chk(q, 8'h36);
        acc(1, 8'h40, 8'h02); acc(0, 8'h40, 0); chk(q, 8'h02);
        acc(1, 8'h40, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(lfsr(seed));
            acc(1, 8'h44, seed[7:0]); acc(1, 8'h48, seed[15:8]); acc(1, 8'h4c, seed[23:16]);
            acc(1, 8'h40, 8'h20); acc(1, 8'h40, 8'h00);
            acc(0, 8'h44, 0); chk(q, seed[7:0]);
            acc(0, 8'h48, 0); chk(q, seed[15:8]);
            acc(0, 8'h4c, 0); chk(q, seed[23:16] & 8'h06);
        end
        acc(1, 8'h40, 8'h20);
        for (int s = 0; s < 2; s++) begin
            seed = lfsr(seed);
            acc(1, 8'h44, {s[0], 4'h0, seed[2:0]} + 8'h03);
            wt(n); wt(n);
            chk(n + 1, s ? 3 * (seed[2:0] + 3) + 11 : 2 * (seed[2:0] + 3) + 9);
        end
        acc(1, 8'h40, 8'h28); ev(1, 0);
        acc(0, 8'h1c, 0); chk(q, 8'h93);
        acc(0, 8'h40, 0); chk(q, 8'h20);
        ev(2, 0); acc(0, 8'h1c, 0); chk(q, 8'h81);
        acc(1, 8'h40, 8'h00); acc(0, 8'h1c, 0); chk(q, 8'h00);
        acc(1, 8'h40, 8'h20); acc(1, 8'h40, 8'h24);
        acc(1, 8'h48, 8'h5a); ab <= 8'h5b; stb <= 1'b1; @(posedge clock);
        stb <= 1'b0; @(posedge clock); chk(m, 4'h8);
        ev(3, 0); chk(hold, 1'b1);
        acc(0, 8'h1c, 0); chk(q, 8'h84);
        acc(0, 8'h1c, 0); chk(q, 8'h00);
        seed = lfsr(seed);
        ev(4, seed[7:0]); chk(hold, 1'b1);
        er <= 4'h2; repeat (2) @(posedge clock); chk(hold, 1'b0); er <= 4'h0;
        acc(0, 8'h1c, 0); chk(q, 8'h88);
        acc(0, 8'h18, 0); chk(q, seed[7:0]);
        acc(0, 8'h1c, 0); chk(q & 8'h7f, 8'h00);
        ev(5, 0); acc(0, 8'h1c, 0); chk(q & 8'h7f, 8'h28);
        txw <= 1'b1; @(posedge clock); txw <= 1'b0; repeat (3) @(posedge clock);
        acc(0, 8'h1c, 0); chk(q & 8'h7f, 8'h00);
        chk(hold, 1'b0);
        summarize();
    end
endmodule
